//--- logic/afp_defines.svh
// Purpose: constants for the amplifier fault protection manager
// Assumes: 100 MHz clock, Avalon-MM register access
// Notes: byte addresses of word registers
`ifndef AFP_DEFINES_SVH
`define AFP_DEFINES_SVH
`define AFP_ADDR_STATUS 4'h0
`define AFP_ADDR_IRQSTAT 4'h4
`define AFP_ADDR_IRQMASK 4'h8
`define AFP_ADDR_MODE 4'hC
`define AFP_MODE_BTL 2'h0
`define AFP_MODE_PARALLEL_BRIDGE_MONO_MODE 2'h2
`define AFP_MODE_SE 2'h3
`define AFP_EV_OLP 0
`define AFP_EV_UVP 1
`define AFP_EV_OTE 2
`define AFP_EV_OTW 3
`define AFP_EV_BST 4
`define AFP_EV_W 5
`endif

//--- logic/afp_pkg.sv
// Purpose: types for the amplifier fault protection manager
// Assumes: nothing beyond the defines header
// Notes: half-bridge order A,B,C,D is bit 0..3
package afp_pkg;
  typedef enum logic [2:0] {
    AFP_RUN = 3'h1,
    AFP_LATCHED = 3'h2,
    AFP_HELD = 3'h4
  } afp_state_e;
  typedef struct packed {
    logic [3:0] overload;
    logic [3:0] bootUv;
    logic supplyUv;
    logic overtemp;
    logic tempWarn;
  } afp_fault_s;
  typedef struct packed {
    logic faultOe;
    logic warnOe;
  } afp_pins_s;
endpackage : afp_pkg

//--- logic/afp_fault_manager.sv
// Purpose: protection and error reporting control of a four half-bridge stage
// Assumes: fault inputs synchronous to clk, reset_n driven by the controller
// Notes: status pins are open drain, oe low means pulling low
`timescale 1ns/1ns
`default_nettype none
`include "afp_defines.svh"
////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - fault and warning pins are active-low open drain, pull low or release
// - any shutdown fault pulls the fault pin low
// - junction temperature warning above 125 C pulls the warning pin low
// - pin pair encodes normal, shutdown fault, warning, or both
// - while reset_n is low the fault pin is released high
// - shutdown fault puts affected half-bridges hi-z at once, fault low
// - faults self-recover except overload and overtemp, which latch
// - mode 00 bridge stereo, 10 parallel mono, 11 four single ended
// - pair shutdown in bridge and single ended, all four in parallel mode
// - bootstrap undervoltage disables its half-bridge only, no latch, no fault
// - reset clears latched overtemp, then normal operation resumes
// - supply undervoltage turns all half-bridges off, recovers automatically
module afp_fault_manager
  import afp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic resetN,
  input wire logic [1:0] modeSel,
  input wire afp_fault_s faultIn,
  output afp_pins_s pinOe,
  output logic [3:0] bridgeHiZ,
  output logic irq,
  input wire logic [3:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWritedata,
  output logic [31:0] avsReaddata,
  output logic avsWaitrequest
);
  ////////////////////////////////////////////////////////////////////////////
  // pair mapping, used for both latched and live shutdown
  function automatic logic [3:0] map_off(input logic [3:0] err, input logic [1:0] m);
    logic [3:0] r;
    r = 4'h0;
    if (m == `AFP_MODE_PARALLEL_BRIDGE_MONO_MODE) begin
      r = {4{|err}};
    end else begin
      r[1:0] = {2{|err[1:0]}};
      r[3:2] = {2{|err[3:2]}};
    end
    return r;
  endfunction : map_off

  afp_state_e state_r, state_nxt;
  logic [3:0] latchedOff_r, latchedOff_nxt;
  logic otLatched_r, otLatched_nxt;
  logic [`AFP_EV_W-1:0] irqStat_r, irqStat_nxt, irqMask_r, irqMask_nxt;
  logic [1:0] modeLatch_r, modeLatch_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic ack_r, ack_nxt;
  logic faultOe_r, faultOe_nxt, warnOe_r, warnOe_nxt;
  logic [3:0] hiz_r, hiz_nxt;
  logic [`AFP_EV_W-1:0] events;
  logic [3:0] olOff;
  logic shutdown;
  logic acc;

  assign acc = (avsRead | avsWrite) & ~ack_r;
  assign avsWaitrequest = acc;
  assign olOff = map_off(faultIn.overload, modeSel);
  assign events = {|faultIn.bootUv, faultIn.tempWarn, faultIn.overtemp,
                   faultIn.supplyUv, |faultIn.overload};

  ////////////////////////////////////////////////////////////////////////////
  // protection state
  always_comb begin
    state_nxt = state_r;
    latchedOff_nxt = latchedOff_r;
    otLatched_nxt = otLatched_r;
    case (state_r)
      AFP_RUN: begin
        if (!resetN) begin
          state_nxt = AFP_HELD;
        end else if (faultIn.overtemp || |faultIn.overload) begin
          state_nxt = AFP_LATCHED;
          latchedOff_nxt = faultIn.overtemp ? 4'hF : olOff;
          otLatched_nxt = faultIn.overtemp;
        end
      end
      AFP_LATCHED: begin
        if (!resetN) begin
          state_nxt = AFP_HELD;
        end else begin
          latchedOff_nxt = latchedOff_r | olOff | {4{faultIn.overtemp}};
          otLatched_nxt = otLatched_r | faultIn.overtemp;
        end
      end
      AFP_HELD: begin
        latchedOff_nxt = 4'h0;
        otLatched_nxt = 1'b0;
        if (resetN) begin
          state_nxt = AFP_RUN;
        end
      end
      default: begin
        state_nxt = AFP_HELD;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs: live faults act in the same cycle path as latched ones
  always_comb begin
    logic [3:0] off;
    off = 4'h0;
    shutdown = 1'b0;
    modeLatch_nxt = modeSel;
    // reset holds the stage quiet too, a design choice
    if (!resetN) begin
      off = 4'hF;
    end else begin
      off = latchedOff_r | olOff;
      if (faultIn.overtemp || faultIn.supplyUv) begin
        off = 4'hF;
      end
      shutdown = (state_r == AFP_LATCHED) | faultIn.overtemp | faultIn.supplyUv
                 | (|faultIn.overload);
      off = off | faultIn.bootUv;
    end
    hiz_nxt = off;
    faultOe_nxt = !(shutdown && resetN);
    warnOe_nxt = !faultIn.tempWarn;
  end

  ////////////////////////////////////////////////////////////////////////////
  // register bus and interrupt status
  always_comb begin
    logic [`AFP_EV_W-1:0] clr;
    clr = '0;
    ack_nxt = acc;
    rdata_nxt = rdata_r;
    irqMask_nxt = irqMask_r;
    // write lands on the edge where waitrequest is seen low, not on the first edge
    if (ack_r && avsWrite) begin
      case (avsAddress)
        `AFP_ADDR_IRQSTAT: clr = avsWritedata[`AFP_EV_W-1:0];
        `AFP_ADDR_IRQMASK: irqMask_nxt = avsWritedata[`AFP_EV_W-1:0];
        default: clr = '0;
      endcase
    end
    if (acc && avsRead) begin
      case (avsAddress)
        `AFP_ADDR_STATUS: rdata_nxt = {24'h0, otLatched_r, (state_r == AFP_LATCHED),
                                       faultOe_r, warnOe_r, hiz_r};
        `AFP_ADDR_IRQSTAT: rdata_nxt = {27'h0, irqStat_r};
        `AFP_ADDR_IRQMASK: rdata_nxt = {27'h0, irqMask_r};
        `AFP_ADDR_MODE: rdata_nxt = {30'h0, modeLatch_r};
        default: rdata_nxt = 32'h0;
      endcase
    end
    // set wins over a simultaneous clear
    irqStat_nxt = (irqStat_r & ~clr) | events;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= AFP_HELD;
      latchedOff_r <= 4'h0;
      otLatched_r <= 1'b0;
      irqStat_r <= '0;
      irqMask_r <= '0;
      modeLatch_r <= 2'h0;
      rdata_r <= 32'h0;
      ack_r <= 1'b0;
      faultOe_r <= 1'b1;
      warnOe_r <= 1'b1;
      hiz_r <= 4'hF;
    end else begin
      state_r <= state_nxt;
      latchedOff_r <= latchedOff_nxt;
      otLatched_r <= otLatched_nxt;
      irqStat_r <= irqStat_nxt;
      irqMask_r <= irqMask_nxt;
      modeLatch_r <= modeLatch_nxt;
      rdata_r <= rdata_nxt;
      ack_r <= ack_nxt;
      faultOe_r <= faultOe_nxt;
      warnOe_r <= warnOe_nxt;
      hiz_r <= hiz_nxt;
    end
  end

  assign pinOe.faultOe = faultOe_r;
  assign pinOe.warnOe = warnOe_r;
  assign bridgeHiZ = hiz_r;
  assign avsReaddata = rdata_r;
  assign irq = |(irqStat_r & irqMask_r);
endmodule : afp_fault_manager
`default_nettype wire

//--- tb/afp_fault_manager_assertions.sv
// Purpose: port checks for the fault manager
// Assumes: default clocking on clk, rst disables
// Notes: bound below
`timescale 1ns/1ns
`default_nettype none
module afp_fault_manager_assertions
  import afp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic resetN,
  input wire logic [1:0] modeSel,
  input wire afp_fault_s faultIn,
  input wire afp_pins_s pinOe,
  input wire logic [3:0] bridgeHiZ,
  input wire logic irq,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic avsWaitrequest
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_fault_low: assert property ($past(resetN) && resetN && |faultIn.overload |=>
    !pinOe.faultOe) else $error("fault pin not low");
  chk_reset_rel: assert property (!resetN |=> pinOe.faultOe && bridgeHiZ == 4'hF)
    else $error("fault pin not released");
  chk_warn_pin: assert property (1'h1 |=> pinOe.warnOe != $past(faultIn.tempWarn))
    else $error("warning pin wrong");
  chk_latch_hold: assert property (($past(resetN) && resetN && |faultIn.overload)
    ##1 (resetN && faultIn == '0)[*3] |=> !pinOe.faultOe) else $error("latch lost");
  chk_uv_all: assert property ($past(resetN) && resetN && faultIn.supplyUv |=>
    bridgeHiZ == 4'hF && !pinOe.faultOe) else $error("undervoltage map");
  chk_boot_only: assert property ($past(resetN) && resetN && pinOe.faultOe &&
    faultIn == 11'h020 |=> pinOe.faultOe && bridgeHiZ == 4'h4) else $error("bootstrap map");
  chk_pair_map: assert property ($past(resetN) && resetN && pinOe.faultOe &&
    modeSel == 2'h0 && faultIn == 11'h200 |=> bridgeHiZ == 4'hC) else $error("pair map");
  chk_par_map: assert property ($past(resetN) && resetN && pinOe.faultOe &&
    modeSel == 2'h2 && faultIn == 11'h080 |=> bridgeHiZ == 4'hF) else $error("parallel map");
  chk_bus_ack: assert property ((avsRead || avsWrite) && avsWaitrequest |=> !avsWaitrequest)
    else $error("bus ack late");
  cover property (resetN && |faultIn.overload);
  cover property (faultIn.bootUv != 4'h0);
  cover property (irq);
endmodule : afp_fault_manager_assertions
bind afp_fault_manager afp_fault_manager_assertions chk_u(.*);
`default_nettype wire

//--- tb/afp_mcu_model.sv
// Purpose: controller model on the status pins
// Assumes: pins read with pull-up level
// Notes: holds resetN low at start
`timescale 1ns/1ns
`default_nettype none
module afp_mcu_model (
  input wire logic clk,
  input wire logic warnPin,
  input wire logic clearReq,
  output logic resetN,
  output logic volDown
);
  logic [3:0] cnt = 4'hF;
  always @(posedge clk) begin
    if (clearReq) cnt <= 4'h3;
    else if (cnt != 4'h0) cnt <= cnt - 4'h1;
  end
  assign resetN = (cnt == 4'h0);
  assign volDown = !warnPin;
endmodule : afp_mcu_model
`default_nettype wire

//--- tb/afp_fault_manager_test.sv
// Purpose: self-checking bench of the fault manager
// Assumes: one-cycle pin latency, one-wait bus
// Notes: pins released read as pulled high
`timescale 1ns/1ns
`default_nettype none
module afp_fault_manager_test;
  import afp_pkg::*;
  logic clk = 1'h0, rst = 1'h1, clearReq = 1'h0, resetN, volDown, irq;
  logic [1:0] modeSel = 2'h0;
  afp_fault_s faultIn = '0;
  afp_pins_s pinOe;
  logic [3:0] bridgeHiZ, avsAddress = 4'h0;
  logic avsRead = 1'h0, avsWrite = 1'h0, avsWaitrequest;
  logic [31:0] avsWritedata = '0, avsReaddata, rd;
  logic [1:0] mt [3] = '{2'h0, 2'h2, 2'h3};
  int err_total = 0, checked = 0;
  always #5 clk = ~clk;
  afp_fault_manager dut_u(.*);
  afp_mcu_model mcu_u(.clk(clk), .warnPin(pinOe.warnOe), .clearReq(clearReq),
    .resetN(resetN), .volDown(volDown));
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avsAddress <= a;
    avsWritedata <= d;
    avsWrite <= wr;
    avsRead <= !wr;
    @(posedge clk);
    while (avsWaitrequest !== 1'h0) @(posedge clk);
    rd = avsReaddata;
    avsWrite <= 1'h0;
    avsRead <= 1'h0;
    @(posedge clk);
  endtask : bus
  task automatic step(input logic [10:0] v);
    faultIn <= v;
    repeat (2) @(posedge clk);
  endtask : step
  task automatic clr;
    clearReq <= 1'h1;
    @(posedge clk);
    clearReq <= 1'h0;
    repeat (8) @(posedge clk);
  endtask : clr
  task automatic end_sim;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    repeat (20) @(posedge clk);
    cmp({pinOe, bridgeHiZ}, 6'h30);
    for (int m = 0; m < 3; m++) for (int b = 0; b < 4; b++) begin
      modeSel <= mt[m];
      step(11'h080 << b);
      cmp({pinOe.faultOe, bridgeHiZ}, {1'h0, m == 1 ? 4'hF : b < 2 ? 4'h3 : 4'hC});
      step(11'h000);
      cmp(pinOe.faultOe, 1'h0);
      clr();
      cmp({pinOe, bridgeHiZ}, 6'h30);
    end
    $display("mode map test done");
    step(11'h004);
    cmp({pinOe.faultOe, bridgeHiZ}, 5'h0F);
    step(11'h020);
    cmp({pinOe.faultOe, bridgeHiZ}, 5'h14);
    step(11'h001);
    cmp({pinOe, volDown}, 3'h5);
    step(11'h003);
    cmp({pinOe, bridgeHiZ}, 6'h0F);
    step(11'h000);
    cmp(pinOe, 2'h1);
    clearReq <= 1'h1;
    repeat (3) @(posedge clk);
    clearReq <= 1'h0;
    cmp(pinOe.faultOe, 1'h1);
    repeat (8) @(posedge clk);
    cmp({pinOe, bridgeHiZ}, 6'h30);
    $display("pin test done");
    bus(1'h1, 4'h4, 32'h1F);
    bus(1'h1, 4'h8, 32'h01);
    bus(1'h0, 4'h8, 32'h0);
    cmp(rd, 32'h01);
    step(11'h080);
    step(11'h000);
    cmp(irq, 1'h1);
    bus(1'h0, 4'h0, 32'h0);
    cmp(rd, 32'h53);
    bus(1'h0, 4'hC, 32'h0);
    cmp(rd, 32'h3);
    bus(1'h0, 4'h4, 32'h0);
    cmp(rd, 32'h01);
    bus(1'h1, 4'h4, 32'h01);
    bus(1'h0, 4'h4, 32'h0);
    cmp({irq, rd}, 33'h0);
    bus(1'h0, 4'h1, 32'h0);
    cmp(rd, 32'h0);
    clr();
    $display("register test done");
    end_sim();
  end
  initial begin
    repeat (3000) @(posedge clk);
    err_total++;
    end_sim();
  end
endmodule : afp_fault_manager_test
`default_nettype wire
